/* hw/ssmx_consts.vh */
`ifndef SSMX_CONSTS_VH
`define SSMX_CONSTS_VH

// ==========================================
// Register byte offsets
`define SSMX_OFF_OPCODE 8'h00
`define SSMX_OFF_DST 8'h04
`define SSMX_OFF_SRC 8'h08
`define SSMX_OFF_FLAGS 8'h0C
`define SSMX_OFF_RESULT 8'h10
`define SSMX_OFF_STATUS 8'h14
`define SSMX_OFF_GUARD 8'h18
`define SSMX_OFF_PC 8'h1C

// ==========================================
// Flag bit positions
`define SSMX_FLAG_C 7
`define SSMX_FLAG_Z 6
`define SSMX_FLAG_S 5
`define SSMX_FLAG_V 4

// ==========================================
// Status bit positions
`define SSMX_ST_BUSY 0
`define SSMX_ST_STOPPED 1
`define SSMX_ST_ILLEGAL 2
`define SSMX_ST_FAILHALT 3

// ==========================================
// Reset values and keys
`define SSMX_RST_PC 16'h0100
`define SSMX_RST_BYTE 8'h00
`define SSMX_GUARD_KEY 8'hA5

// ==========================================
// Opcodes and groups
`define SSMX_OP_ASR_R 8'hD0
`define SSMX_OP_ASR_IR 8'hD1
`define SSMX_OP_HALT 8'h7F
`define SSMX_HI_SUB 4'h2
`define SSMX_HI_CMT 4'h6
`define SSMX_HI_MT 4'h7
`define SSMX_HI_XOR 4'hB

// ==========================================
// Timing in instruction cycles and lengths in bytes
`define SSMX_CYC_SHORT 3'h4
`define SSMX_CYC_LONG 3'h6
`define SSMX_LEN_ONE 2'h1
`define SSMX_LEN_TWO 2'h2
`define SSMX_LEN_THREE 2'h3

`endif

/* hw/ssmx_alu.v */
`timescale 1ns/1ps
`include "ssmx_consts.vh"

module ssmx_alu (
	// Instruction
	input wire [7:0] opcode,
	input wire [7:0] dst,
	input wire [7:0] src,
	input wire [7:0] flags_in,
	// Outcome
	output reg [7:0] result,
	output reg [7:0] flags_out,
	output reg write_dst,
	output reg is_halt,
	output reg legal,
	output reg [1:0] length,
	output reg [2:0] cycles
);
	reg [8:0] diff;
	reg [7:0] r;
	reg pair_ok;

	always @* begin
		diff = {1'b0, dst} - {1'b0, src};
		r = 8'h00;
		result = dst;
		flags_out = flags_in;
		write_dst = 1'b0;
		is_halt = 1'b0;
		legal = 1'b1;
		length = `SSMX_LEN_TWO;
		cycles = `SSMX_CYC_SHORT;
		pair_ok = (opcode[3:0] >= 4'h2) && (opcode[3:0] <= 4'h6);
		// Operand form timing for two-operand groups
		case (opcode[3:0])
			4'h2: begin
				length = `SSMX_LEN_TWO;
				cycles = `SSMX_CYC_SHORT;
			end
			4'h3: begin
				length = `SSMX_LEN_TWO;
				cycles = `SSMX_CYC_LONG;
			end
			default: begin
				length = `SSMX_LEN_THREE;
				cycles = `SSMX_CYC_LONG;
			end
		endcase
		if (opcode == `SSMX_OP_ASR_R || opcode == `SSMX_OP_ASR_IR) begin
			length = `SSMX_LEN_TWO;
			cycles = `SSMX_CYC_SHORT;
			r = {dst[7], dst[7:1]};
			result = r;
			write_dst = 1'b1;
			flags_out[`SSMX_FLAG_C] = dst[0];
			flags_out[`SSMX_FLAG_Z] = (r == 8'h00);
			flags_out[`SSMX_FLAG_S] = r[7];
			flags_out[`SSMX_FLAG_V] = 1'b0;
		end else if (opcode == `SSMX_OP_HALT) begin
			// No flag changes
			length = `SSMX_LEN_ONE;
			cycles = `SSMX_CYC_SHORT;
			is_halt = 1'b1;
		end else if (pair_ok && opcode[7:4] == `SSMX_HI_SUB) begin
			r = diff[7:0];
			result = r;
			write_dst = 1'b1;
			flags_out[`SSMX_FLAG_C] = diff[8];
			flags_out[`SSMX_FLAG_Z] = (r == 8'h00);
			flags_out[`SSMX_FLAG_S] = r[7];
			flags_out[`SSMX_FLAG_V] = (dst[7] != src[7]) && (r[7] == src[7]);
		end else if (pair_ok && opcode[7:4] == `SSMX_HI_CMT) begin
			r = (~dst) & src;
			result = r;
			flags_out[`SSMX_FLAG_Z] = (r == 8'h00);
			flags_out[`SSMX_FLAG_S] = r[7];
			flags_out[`SSMX_FLAG_V] = 1'b0;
		end else if (pair_ok && opcode[7:4] == `SSMX_HI_MT) begin
			r = dst & src;
			result = r;
			flags_out[`SSMX_FLAG_Z] = (r == 8'h00);
			flags_out[`SSMX_FLAG_S] = r[7];
			flags_out[`SSMX_FLAG_V] = 1'b0;
		end else if (pair_ok && opcode[7:4] == `SSMX_HI_XOR) begin
			r = dst ^ src;
			result = r;
			write_dst = 1'b1;
			flags_out[`SSMX_FLAG_Z] = (r == 8'h00);
			flags_out[`SSMX_FLAG_S] = r[7];
			flags_out[`SSMX_FLAG_V] = 1'b0;
		end else begin
			legal = 1'b0;
		end
	end
endmodule

/* hw/ssmx_unit.v */
`timescale 1ns/1ps
`include "ssmx_consts.vh"

// What this block does
// - Shift right arithmetic (D0, D1) moves bits toward bit 0 and keeps bit 7, copying it into bit 6.
// - That shift puts old bit 0 in carry, sets zero and sign from the result and clears overflow.
// - Halt (7F, one byte) stops the clocks, enters stop, keeps flags and all registers except the PC, which advances by one.
// - Stop is left only by reset or the external interrupt input, restarting the oscillator.
// - A halt while the guard register is not A5 does not stop but loads the PC with the reset address.
// - Subtract (22 to 26) writes destination minus source by two's complement, source untouched.
// - Subtract sets carry on borrow, zero, sign, and overflow on sign mismatch with result like source.
// - Complement mask test (62 to 66) tests inverted destination AND mask for zero, writing result and flags but not destination.
// - Both mask tests keep operands and carry, set sign from result bit 7 and clear overflow.
// - Mask test (72 to 76) tests destination AND mask for zero, writing result and flags but not destination.
// - Exclusive OR (B2 to B6) stores dst XOR src, sets zero and sign, clears overflow, keeps carry.
// - Reset loads the PC with 0100, the same address used by a failed halt.
module ssmx_unit (
	// Clock and reset
	input wire clk,
	input wire rst_n,
	input wire ce,
	// Wishbone slave
	input wire wb_cyc_i,
	input wire wb_stb_i,
	input wire wb_we_i,
	input wire [7:0] wb_adr_i,
	input wire [3:0] wb_sel_i,
	input wire [31:0] wb_dat_i,
	output reg [31:0] wb_dat_o,
	output reg wb_ack_o,
	// Wake source
	input wire ext_int,
	// Power state
	output reg stopped,
	output reg osc_en
);
	// ==========================================
	// Architectural state
	reg [7:0] opcode;
	reg [7:0] dst;
	reg [7:0] src;
	reg [7:0] flags;
	reg [7:0] result;
	reg [7:0] halt_guard_register;
	reg [15:0] pc;
	reg busy;
	reg illegal;
	reg fail_halt;
	reg [2:0] count;

	wire [7:0] alu_result;
	wire [7:0] alu_flags;
	wire alu_write;
	wire alu_halt;
	wire alu_legal;
	wire [1:0] alu_length;
	wire [2:0] alu_cycles;

	ssmx_alu u_alu (
		.opcode(opcode),
		.dst(dst),
		.src(src),
		.flags_in(flags),
		.result(alu_result),
		.flags_out(alu_flags),
		.write_dst(alu_write),
		.is_halt(alu_halt),
		.legal(alu_legal),
		.length(alu_length),
		.cycles(alu_cycles)
	);

	// ==========================================
	// Bus decode
	wire req = wb_cyc_i && wb_stb_i && !wb_ack_o;
	wire wr = req && wb_we_i;
	wire wr_lo = wr && wb_sel_i[0];
	wire wr_hi = wr && wb_sel_i[1];
	wire hit_opcode = (wb_adr_i == `SSMX_OFF_OPCODE);
	wire hit_dst = (wb_adr_i == `SSMX_OFF_DST);
	wire hit_src = (wb_adr_i == `SSMX_OFF_SRC);
	wire hit_flags = (wb_adr_i == `SSMX_OFF_FLAGS);
	wire hit_guard = (wb_adr_i == `SSMX_OFF_GUARD);
	wire hit_pc = (wb_adr_i == `SSMX_OFF_PC);
	// Software writes to operands are held off while an instruction runs or the core sleeps
	wire sw_ok = !busy && !stopped;
	wire start = wr_lo && hit_opcode && sw_ok;
	wire last = busy && (count == 3'h1);

	reg [31:0] next_rdata;

	always @* begin
		next_rdata = 32'h0000_0000;
		case (wb_adr_i)
			`SSMX_OFF_OPCODE: next_rdata = {24'h000000, opcode};
			`SSMX_OFF_DST: next_rdata = {24'h000000, dst};
			`SSMX_OFF_SRC: next_rdata = {24'h000000, src};
			`SSMX_OFF_FLAGS: next_rdata = {24'h000000, flags};
			`SSMX_OFF_RESULT: next_rdata = {24'h000000, result};
			`SSMX_OFF_STATUS: begin
				next_rdata[`SSMX_ST_BUSY] = busy;
				next_rdata[`SSMX_ST_STOPPED] = stopped;
				next_rdata[`SSMX_ST_ILLEGAL] = illegal;
				next_rdata[`SSMX_ST_FAILHALT] = fail_halt;
			end
			`SSMX_OFF_GUARD: next_rdata = {24'h000000, halt_guard_register};
			`SSMX_OFF_PC: next_rdata = {16'h0000, pc};
			default: next_rdata = 32'h0000_0000;
		endcase
	end

	// ==========================================
	// Bus answer, one cycle after the request
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h0000_0000;
		end else if (ce) begin
			wb_ack_o <= req;
			if (req && !wb_we_i) begin
				wb_dat_o <= next_rdata;
			end
		end
	end

	// ==========================================
	// Operand, guard and PC registers
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			opcode <= `SSMX_RST_BYTE;
			dst <= `SSMX_RST_BYTE;
			src <= `SSMX_RST_BYTE;
			flags <= `SSMX_RST_BYTE;
			result <= `SSMX_RST_BYTE;
			halt_guard_register <= `SSMX_RST_BYTE;
			pc <= `SSMX_RST_PC;
		end else if (ce) begin
			if (wr_lo && sw_ok) begin
				if (hit_opcode) begin
					opcode <= wb_dat_i[7:0];
				end
				if (hit_dst) begin
					dst <= wb_dat_i[7:0];
				end
				if (hit_src) begin
					src <= wb_dat_i[7:0];
				end
				if (hit_flags) begin
					flags <= wb_dat_i[7:0];
				end
				if (hit_guard) begin
					halt_guard_register <= wb_dat_i[7:0];
				end
				if (hit_pc) begin
					pc[7:0] <= wb_dat_i[7:0];
				end
			end
			if (wr_hi && sw_ok && hit_pc) begin
				pc[15:8] <= wb_dat_i[15:8];
			end
			if (last && alu_legal) begin
				if (alu_halt) begin
					if (halt_guard_register != `SSMX_GUARD_KEY) begin
						pc <= `SSMX_RST_PC;
					end else begin
						pc <= pc + {14'h0000, alu_length};
					end
				end else begin
					flags <= alu_flags;
					result <= alu_result;
					pc <= pc + {14'h0000, alu_length};
					if (alu_write) begin
						dst <= alu_result;
					end
				end
			end
		end
	end

	// ==========================================
	// Execution sequencing and stop state
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			busy <= 1'b0;
			count <= 3'h0;
			illegal <= 1'b0;
			fail_halt <= 1'b0;
			stopped <= 1'b0;
			osc_en <= 1'b1;
		end else if (ce) begin
			if (start) begin
				busy <= 1'b1;
				count <= 3'h0;
				illegal <= 1'b0;
				fail_halt <= 1'b0;
			end else if (busy && count == 3'h0) begin
				// Latch the cycle length once the opcode register has settled
				count <= alu_cycles;
				if (!alu_legal) begin
					busy <= 1'b0;
					illegal <= 1'b1;
				end
			end else if (last) begin
				busy <= 1'b0;
				count <= 3'h0;
				if (alu_halt) begin
					if (halt_guard_register == `SSMX_GUARD_KEY) begin
						stopped <= 1'b1;
						osc_en <= 1'b0;
					end else begin
						fail_halt <= 1'b1;
					end
				end
			end else if (busy) begin
				count <= count - 3'h1;
			end
			// Only the interrupt pin or reset can end stop
			if (stopped && ext_int) begin
				stopped <= 1'b0;
				osc_en <= 1'b1;
			end
		end
	end
endmodule

/* testbench/ssmx_unit_asserts.sv */
`timescale 1ns/1ps
module ssmx_unit_asserts (
	// Clock and bus
	input wire clk,
	input wire rst_n,
	input wire ce,
	input wire wb_cyc_i,
	input wire wb_stb_i,
	input wire wb_ack_o,
	// Power
	input wire ext_int,
	input wire stopped,
	input wire osc_en
);
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	a_ack_follows_req: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o && ce |=> wb_ack_o)
		else $error("ack missing");
	a_ack_one_pulse: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack too long");
	a_ack_needs_req: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
		else $error("ack without request");
	a_stop_osc_off: assert property (stopped |-> !osc_en)
		else $error("oscillator runs in stop");
	a_stop_entry_osc: assert property ($rose(stopped) |-> $fell(osc_en))
		else $error("stop entry without oscillator halt");
	a_stop_holds: assert property (stopped && !ext_int |=> stopped)
		else $error("stop left without wake");
	a_wake_by_int: assert property (stopped && ext_int && ce |=> !stopped && osc_en)
		else $error("no wake on interrupt");
	a_osc_restart: assert property ($rose(osc_en) |-> $past(ext_int) && !stopped)
		else $error("oscillator restart without wake");
endmodule
bind ssmx_unit ssmx_unit_asserts chk_u (.clk(clk), .rst_n(rst_n), .ce(ce), .wb_cyc_i(wb_cyc_i),
	.wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o), .ext_int(ext_int), .stopped(stopped),
	.osc_en(osc_en));

/* testbench/ssmx_unit_bench.sv */
`timescale 1ns/1ps
`include "ssmx_consts.vh"
module ssmx_unit_bench;
	reg clk = 0, rst_n = 0, cyc = 0, stb = 0, we = 0, ext_int = 0;
	reg [7:0] adr = 0, op, d, s, f;
	reg [31:0] dat = 0, rv;
	wire [31:0] dat_o;
	wire ack, stopped, osc_en;
	integer errors = 0, checks_done = 0, k, g, n;
	reg [16:0] m;
	reg [15:0] pairs [2:6];
	ssmx_unit dut_u (.clk(clk), .rst_n(rst_n), .ce(1'b1), .wb_cyc_i(cyc), .wb_stb_i(stb),
		.wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(dat), .wb_dat_o(dat_o),
		.wb_ack_o(ack), .ext_int(ext_int), .stopped(stopped), .osc_en(osc_en));
	initial begin
		forever #2 clk = ~clk;
	end
	task finish_test;
		begin
			if (errors == 0 && checks_done > 0)
				$display("All tests passed");
			else
				$display("Some tests failed");
			$finish;
		end
	endtask
	task chk(input string nm, input [31:0] seen, input [31:0] exp);
		begin
			checks_done = checks_done + 1;
			if (seen !== exp) begin
				errors = errors + 1;
				$display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
			end
		end
	endtask
	// One classic cycle, waits for ack
	task bus(input w, input [7:0] a, input [31:0] dv);
		integer t;
		begin
			@(posedge clk);
			cyc <= 1;
			stb <= 1;
			we <= w;
			adr <= a;
			dat <= dv;
			t = 0;
			do begin
				@(posedge clk);
				t = t + 1;
			end while (ack !== 1'b1 && t < 20);
			rv = dat_o;
			cyc <= 0;
			stb <= 0;
			if (t >= 20) begin
				errors = errors + 1;
				finish_test;
			end
		end
	endtask
	task rdc(input string nm, input [7:0] a, input [31:0] exp);
		begin
			bus(0, a, 0);
			chk(nm, rv, exp);
		end
	endtask
	task wait_idle;
		begin
			for (n = 0; n < 20; n = n + 1) begin
				bus(0, `SSMX_OFF_STATUS, 0);
				if (rv[`SSMX_ST_BUSY] === 1'b0)
					n = 30;
			end
			if (n < 30) begin
				errors = errors + 1;
				finish_test;
			end
		end
	endtask
	task wait_stop(input v);
		begin
			for (k = 0; k < 40 && stopped !== v; k = k + 1)
				@(posedge clk);
			if (k >= 40) begin
				errors = errors + 1;
				finish_test;
			end
		end
	endtask
	// Expected {write, result, C, Z, S, V, low flags}
	function automatic [16:0] model(input [7:0] o, input [7:0] a, input [7:0] b, input [7:0] fl);
		reg [8:0] t;
		reg [7:0] r;
		reg c, v, w;
		begin
			c = fl[7];
			v = 1'b0;
			w = 1'b1;
			case (o[7:4])
				4'hD: begin
					r = {a[7], a[7:1]};
					c = a[0];
				end
				4'h2: begin
					t = {1'b0, a} - {1'b0, b};
					r = t[7:0];
					c = t[8];
					v = (a[7] ^ b[7]) & (r[7] == b[7]);
				end
				4'h6: begin
					r = ~a & b;
					w = 1'b0;
				end
				4'h7: begin
					r = a & b;
					w = 1'b0;
				end
				default: r = a ^ b;
			endcase
			model = {w, r, c, r == 8'h00, r[7], v, fl[3:0]};
		end
	endfunction
	task run;
		begin
			m = model(op, d, s, f);
			bus(1, `SSMX_OFF_DST, d);
			bus(1, `SSMX_OFF_SRC, s);
			bus(1, `SSMX_OFF_FLAGS, f);
			bus(1, `SSMX_OFF_PC, 0);
			bus(1, `SSMX_OFF_OPCODE, op);
			wait_idle;
			rdc("dst", `SSMX_OFF_DST, m[16] ? m[15:8] : d);
			rdc("src", `SSMX_OFF_SRC, s);
			rdc("result", `SSMX_OFF_RESULT, m[15:8]);
			rdc("flags", `SSMX_OFF_FLAGS, m[7:0]);
			rdc("pc", `SSMX_OFF_PC, (op[7:4] == 4'hD || op[3:0] < 4) ? 2 : 3);
		end
	endtask
	initial begin
		pairs[2] = 16'h2190;
		pairs[3] = 16'h2165;
		pairs[4] = 16'hC702;
		pairs[5] = 16'h2B54;
		pairs[6] = 16'h5A5A;
		repeat (10) @(posedge clk);
		rst_n <= 1;
		rdc("pc reset", `SSMX_OFF_PC, `SSMX_RST_PC);
		rdc("unmapped", 8'h20, 0);
		bus(1, `SSMX_OFF_DST, 8'h5C);
		bus(1, `SSMX_OFF_OPCODE, 8'h21);
		wait_idle;
		chk("illegal bit", rv[`SSMX_ST_ILLEGAL], 1);
		rdc("dst illegal", `SSMX_OFF_DST, 8'h5C);
		f = 8'h80;
		for (g = 0; g < 2; g = g + 1) begin
			op = `SSMX_OP_ASR_R + g;
			d = g ? 8'h01 : 8'h9A;
			s = 8'h00;
			run;
		end
		for (g = 0; g < 4; g = g + 1) begin
			for (k = 2; k <= 6; k = k + 1) begin
				op = {g == 0 ? 4'h2 : g == 1 ? 4'h6 : g == 2 ? 4'h7 : 4'hB, k[3:0]};
				{d, s} = pairs[k];
				f = k[0] ? 8'h80 : 8'h00;
				run;
			end
		end
		bus(1, `SSMX_OFF_GUARD, 8'h5A);
		bus(1, `SSMX_OFF_PC, 16'h1234);
		bus(1, `SSMX_OFF_OPCODE, `SSMX_OP_HALT);
		wait_idle;
		chk("fail bit", rv[`SSMX_ST_FAILHALT], 1);
		rdc("pc fail", `SSMX_OFF_PC, `SSMX_RST_PC);
		chk("no stop", stopped, 0);
		bus(1, `SSMX_OFF_GUARD, `SSMX_GUARD_KEY);
		bus(1, `SSMX_OFF_DST, 8'h11);
		bus(1, `SSMX_OFF_FLAGS, 8'hF0);
		bus(1, `SSMX_OFF_OPCODE, `SSMX_OP_HALT);
		wait_stop(1);
		bus(1, `SSMX_OFF_DST, 8'h33);
		rdc("dst kept", `SSMX_OFF_DST, 8'h11);
		rdc("flags kept", `SSMX_OFF_FLAGS, 8'hF0);
		ext_int <= 1;
		wait_stop(0);
		ext_int <= 0;
		chk("osc on", osc_en, 1);
		rdc("pc halt", `SSMX_OFF_PC, 16'h0101);
		bus(1, `SSMX_OFF_OPCODE, `SSMX_OP_HALT);
		wait_stop(1);
		// Wake by reset, held several cycles
		rst_n <= 0;
		repeat (4) @(posedge clk);
		rst_n <= 1;
		chk("stop reset", stopped, 0);
		rdc("pc rst", `SSMX_OFF_PC, `SSMX_RST_PC);
		rdc("guard rst", `SSMX_OFF_GUARD, `SSMX_RST_BYTE);
		finish_test;
	end
endmodule
